//--- src/bus_buffer.sv
// connection control of a hot-swappable two-wire bus buffer
// assumes open-drain lines with external pull-ups; the bench resolves the wires
`timescale 1ns/1ps
`include "bus_buffer_regs.svh"

module bus_buffer
	import bus_buffer_pkg::*;
#(
	parameter int STUCK_CYCLES = `STUCK_CYCLES,
	parameter int IDLE_CYCLES = `IDLE_CYCLES
)
(
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// control
	input wire logic ENABLE,
	// backplane side lines
	input wire logic BACKPLANE_DATA_LINE_I,
	output logic BACKPLANE_DATA_LINE_O,
	output logic BACKPLANE_DATA_LINE_OE,
	input wire logic BACKPLANE_CLOCK_LINE_I,
	output logic BACKPLANE_CLOCK_LINE_O,
	output logic BACKPLANE_CLOCK_LINE_OE,
	// card side lines
	input wire logic CARD_DATA_LINE_I,
	output logic CARD_DATA_LINE_O,
	output logic CARD_DATA_LINE_OE,
	input wire logic CARD_CLOCK_LINE_I,
	output logic CARD_CLOCK_LINE_O,
	output logic CARD_CLOCK_LINE_OE,
	// open-drain connection status
	output logic READY_O,
	output logic READY_OE
);
	// -------------------------------------------------------------------------
	// filtered pins: [0] bp data, [1] bp clock, [2] card data, [3] card clock,
	// [4] enable
	// -------------------------------------------------------------------------
	pin_levels_if lv ();

	pin_filter u_filter
	(
		.clk(CLK),
		.arst_n(ARST_N),
		.pins({ENABLE, CARD_CLOCK_LINE_I, CARD_DATA_LINE_I,
			BACKPLANE_CLOCK_LINE_I, BACKPLANE_DATA_LINE_I}),
		.lv(lv)
	);

	logic [1:0] bp_lvl;
	logic [1:0] card_lvl;
	logic en;
	logic stop_seen;

	assign bp_lvl = lv.lvl[1:0];
	assign card_lvl = lv.lvl[3:2];
	assign en = lv.lvl[4];
	// stop: backplane data rises while backplane clock is high
	assign stop_seen = lv.rise[0] & lv.lvl[1];

	// -------------------------------------------------------------------------
	// timers
	// -------------------------------------------------------------------------
	conn_state_t state_q;
	conn_state_t state_d;
	logic [23:0] stuck_q;
	logic [23:0] idle_q;
	logic stuck_hit;
	logic idle_hit;

	assign stuck_hit = (stuck_q == 24'(STUCK_CYCLES - 1));
	assign idle_hit = (idle_q == 24'(IDLE_CYCLES - 1));

	// stuck-low timer counts one unbroken low period on the card side
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			stuck_q <= 24'h000000;
		else if (((state_q != ST_WAIT) && (state_q != ST_LINK)) || (&card_lvl))
			stuck_q <= 24'h000000;
		else if (!stuck_hit)
			stuck_q <= stuck_q + 24'h000001;
	end

	// idle timer needs both backplane lines high without a break
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			idle_q <= 24'h000000;
		else if ((state_q != ST_WAIT) || !(&bp_lvl))
			idle_q <= 24'h000000;
		else if (!idle_hit)
			idle_q <= idle_q + 24'h000001;
	end

	// -------------------------------------------------------------------------
	// recovery pulse generator on the card clock line
	// -------------------------------------------------------------------------
	logic [9:0] half_q;
	logic pulse_low_q;
	logic [4:0] pulses_q;
	logic half_end;
	logic pulse_done;

	assign half_end = (half_q == 10'(`PULSE_HALF_CYCLES - 1));
	// stop early once the card data line is released: the bus is free
	assign pulse_done = (state_q == ST_PULSE) && half_end && !pulse_low_q &&
		((pulses_q == 5'(`PULSE_MAX)) || card_lvl[0]);

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			half_q <= 10'h000;
			pulse_low_q <= 1'b1;
			pulses_q <= 5'h00;
		end
		else if (state_q != ST_PULSE)
		begin
			half_q <= 10'h000;
			pulse_low_q <= 1'b1;
			pulses_q <= 5'h00;
		end
		else if (!half_end)
			half_q <= half_q + 10'h001;
		else
		begin
			half_q <= 10'h000;
			if (pulse_low_q)
			begin
				pulse_low_q <= 1'b0;
				pulses_q <= pulses_q + 5'h01;
			end
			else
				pulse_low_q <= 1'b1;
		end
	end

	// -------------------------------------------------------------------------
	// connection state machine
	// -------------------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_OFF:
				if (en)
					state_d = ST_WAIT;
			ST_WAIT:
				if (!en)
					state_d = ST_OFF;
				else if (stuck_hit)
					state_d = ST_PULSE;
				else if (stop_seen || idle_hit)
					state_d = ST_LINK;
			ST_LINK:
				if (!en)
					state_d = ST_OFF;
				else if (stuck_hit)
					state_d = ST_PULSE;
			ST_PULSE:
				if (!en)
					state_d = ST_OFF;
				else if (pulse_done)
					state_d = ST_CLEAR;
			ST_CLEAR:
				if (!en)
					state_d = ST_OFF;
				else if (&card_lvl)
					state_d = ST_LINK;
			default:
				state_d = ST_OFF;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			state_q <= ST_OFF;
		else
			state_q <= state_d;
	end

	// -------------------------------------------------------------------------
	// buffer direction per line; the side that pulled low first owns the line, the backplane side if both did in one cycle
	// -------------------------------------------------------------------------
	line_owner_t own_q [2];
	logic [3:0] blank_q [2];

	// after release the far side is ignored for a while, because its own low
	// level still travels through the filter and would otherwise latch back
	function automatic line_owner_t next_owner(line_owner_t cur, logic bp, logic card,
		logic blanked);
		line_owner_t nxt;
		nxt = cur;
		case (cur)
			OWN_NONE:
				if (!blanked && !bp)
					nxt = OWN_BP;
				else if (!blanked && !card)
					nxt = OWN_CARD;
			OWN_BP:
				if (bp)
					nxt = OWN_NONE;
			OWN_CARD:
				if (card)
					nxt = OWN_NONE;
			default:
				nxt = OWN_NONE;
		endcase
		return nxt;
	endfunction

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			for (int i = 0; i < 2; i++)
			begin
				own_q[i] <= OWN_NONE;
				blank_q[i] <= 4'h0;
			end
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (state_q != ST_LINK)
				begin
					own_q[i] <= OWN_NONE;
					blank_q[i] <= 4'h0;
				end
				else
				begin
					own_q[i] <= next_owner(own_q[i], bp_lvl[i], card_lvl[i],
						blank_q[i] != 4'h0);
					if ((own_q[i] != OWN_NONE) &&
						(next_owner(own_q[i], bp_lvl[i], card_lvl[i], 1'b1) == OWN_NONE))
						blank_q[i] <= 4'(`BLANK_CYCLES);
					else if (blank_q[i] != 4'h0)
						blank_q[i] <= blank_q[i] - 4'h1;
				end
			end
		end
	end

	// -------------------------------------------------------------------------
	// pin drivers, all registered; lines only ever pull low
	// -------------------------------------------------------------------------
	logic bp_data_oe_q;
	logic bp_clk_oe_q;
	logic card_data_oe_q;
	logic card_clk_oe_q;
	logic ready_oe_q;
	logic low_q;

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			bp_data_oe_q <= 1'b0;
			bp_clk_oe_q <= 1'b0;
			card_data_oe_q <= 1'b0;
			card_clk_oe_q <= 1'b0;
		end
		else
		begin
			bp_data_oe_q <= (state_q == ST_LINK) && (own_q[0] == OWN_CARD);
			bp_clk_oe_q <= (state_q == ST_LINK) && (own_q[1] == OWN_CARD);
			card_data_oe_q <= (state_q == ST_LINK) && (own_q[0] == OWN_BP);
			card_clk_oe_q <= ((state_q == ST_LINK) && (own_q[1] == OWN_BP)) ||
				((state_q == ST_PULSE) && pulse_low_q);
		end
	end

	// ready is released high while connected, pulled low otherwise
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ready_oe_q <= 1'b1;
			low_q <= 1'b0;
		end
		else
		begin
			ready_oe_q <= (state_d != ST_LINK);
			low_q <= 1'b0;
		end
	end

	assign BACKPLANE_DATA_LINE_O = low_q;
	assign BACKPLANE_DATA_LINE_OE = bp_data_oe_q;
	assign BACKPLANE_CLOCK_LINE_O = low_q;
	assign BACKPLANE_CLOCK_LINE_OE = bp_clk_oe_q;
	assign CARD_DATA_LINE_O = low_q;
	assign CARD_DATA_LINE_OE = card_data_oe_q;
	assign CARD_CLOCK_LINE_O = low_q;
	assign CARD_CLOCK_LINE_OE = card_clk_oe_q;
	assign READY_O = low_q;
	assign READY_OE = ready_oe_q;
endmodule

//--- src/bus_buffer_pkg.sv
// types shared by the bus buffer modules
// assumes nothing beyond a SystemVerilog tool
package bus_buffer_pkg;

	// connection state, one-hot
	typedef enum logic [4:0]
	{
		ST_OFF = 5'h01,
		ST_WAIT = 5'h02,
		ST_LINK = 5'h04,
		ST_PULSE = 5'h08,
		ST_CLEAR = 5'h10
	} conn_state_t;

	// which side currently pulls a connected line low
	typedef enum logic [1:0]
	{
		OWN_NONE = 2'h0,
		OWN_BP = 2'h1,
		OWN_CARD = 2'h2
	} line_owner_t;

endpackage

//--- src/bus_buffer_regs.svh
// timing constants for the two-wire bus buffer connection control
// assumes a 125 MHz timing clock; counts are derived from the nominal times
`ifndef BUS_BUFFER_REGS_SVH
`define BUS_BUFFER_REGS_SVH

// -----------------------------------------------------------------------------
// clock and times
// -----------------------------------------------------------------------------
`define CLK_PERIOD_PS 8000
`define STUCK_TIME_MS 30
`define IDLE_TIME_US 95
`define PULSE_HALF_US 5
`define PULSE_MAX 16

// -----------------------------------------------------------------------------
// derived cycle counts (longest times round down, least times round up)
// -----------------------------------------------------------------------------
// scaled in nanoseconds so that the product stays inside a 32-bit integer
`define STUCK_CYCLES ((`STUCK_TIME_MS * 1000000) / (`CLK_PERIOD_PS / 1000))
`define IDLE_CYCLES ((`IDLE_TIME_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PULSE_HALF_CYCLES ((`PULSE_HALF_US * 1000000) / `CLK_PERIOD_PS)
`define BLANK_CYCLES 8

`endif

//--- src/pin_filter.sv
// three-flop synchroniser and agreement filter for the asynchronous inputs
// assumes lines idle high (pulled up) and the enable idles low after reset
`timescale 1ns/1ps

module pin_filter
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// raw pins
	input wire logic [4:0] pins,
	// filtered levels
	pin_levels_if.src lv
);
	logic [4:0] s1_q;
	logic [4:0] s2_q;
	logic [4:0] s3_q;
	logic [4:0] lvl_q;
	logic [4:0] rise_q;
	logic [4:0] fall_q;

	// -------------------------------------------------------------------------
	// synchroniser chain; s1 feeds only s2
	// -------------------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_q <= 5'h0F; // enable starts off, so no false wait follows reset
			s2_q <= 5'h0F;
			s3_q <= 5'h0F;
		end
		else
		begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts only once the second and third stages agree
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lvl_q <= 5'h0F;
			rise_q <= 5'h00;
			fall_q <= 5'h00;
		end
		else
		begin
			for (int i = 0; i < 5; i++)
			begin
				rise_q[i] <= 1'b0;
				fall_q[i] <= 1'b0;
				if (s2_q[i] == s3_q[i])
				begin
					lvl_q[i] <= s3_q[i];
					rise_q[i] <= s3_q[i] & ~lvl_q[i];
					fall_q[i] <= ~s3_q[i] & lvl_q[i];
				end
			end
		end
	end

	assign lv.lvl = lvl_q;
	assign lv.rise = rise_q;
	assign lv.fall = fall_q;
endmodule

//--- src/pin_levels_if.sv
// filtered pin levels and edges passed from the pin filter to the control
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface pin_levels_if;
	logic [4:0] lvl;
	logic [4:0] rise;
	logic [4:0] fall;

	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface

//--- tb/bus_buffer_props.sv
// checker of the buffer's port behaviour
// assumes the bind hands on the stuck and idle counts
`timescale 1ns/1ps
module bus_buffer_props
#(
	parameter int STUCK_CYCLES = 200,
	parameter int IDLE_CYCLES = 50
)
(
	// clock, reset, control
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic ENABLE,
	// wire levels
	input wire logic BACKPLANE_DATA_LINE_I,
	input wire logic BACKPLANE_CLOCK_LINE_I,
	input wire logic CARD_DATA_LINE_I,
	input wire logic CARD_CLOCK_LINE_I,
	// pulls and status
	input wire logic BACKPLANE_DATA_LINE_OE,
	input wire logic BACKPLANE_CLOCK_LINE_OE,
	input wire logic CARD_DATA_LINE_OE,
	input wire logic CARD_CLOCK_LINE_OE,
	input wire logic READY_O,
	input wire logic READY_OE,
	// open-drain drive values
	input wire logic BACKPLANE_DATA_LINE_O,
	input wire logic BACKPLANE_CLOCK_LINE_O,
	input wire logic CARD_DATA_LINE_O,
	input wire logic CARD_CLOCK_LINE_O
);
	// ----
	// run counters: card low run, quiet run, recovery pulses
	// ----
	int low_q;
	int hi_q;
	int pls_q;
	logic cl_oe_q;
	logic quiet;
	assign quiet = CARD_DATA_LINE_I && CARD_CLOCK_LINE_I;
	// raw levels lead the filtered ones, so the bounds carry a margin
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			low_q <= 0;
			hi_q <= 0;
			pls_q <= 0;
			cl_oe_q <= 1'b0;
		end
		else
		begin
			low_q <= (quiet || !ENABLE) ? 0 : low_q + 1;
			hi_q <= (quiet && ENABLE && BACKPLANE_DATA_LINE_I && BACKPLANE_CLOCK_LINE_I) ?
				hi_q + 1 : 0;
			// edge kept by hand: the reset in the event list blurs an inferred clock
			cl_oe_q <= CARD_CLOCK_LINE_OE;
			pls_q <= READY_OE ? pls_q + int'(CARD_CLOCK_LINE_OE && !cl_oe_q) : 0;
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	stuck_break_a: assert property (low_q == STUCK_CYCLES + 10 |-> READY_OE)
		else $error("link kept after stuck low");
	pulse_limit_a: assert property (pls_q <= 16)
		else $error("too many recovery pulses");
	quiet_link_a: assert property (hi_q == IDLE_CYCLES + 20 |-> !READY_OE)
		else $error("no link on a quiet bus");
	connect_gate_a: assert property ($fell(READY_OE) |->
		$past(BACKPLANE_CLOCK_LINE_I, 5) || $past(CARD_CLOCK_LINE_I, 5))
		else $error("link made with clock low");
	enable_off_a: assert property (!ENABLE [*8] |=> READY_OE && !CARD_DATA_LINE_OE &&
		!CARD_CLOCK_LINE_OE && !BACKPLANE_DATA_LINE_OE && !BACKPLANE_CLOCK_LINE_OE)
		else $error("link kept with enable low");
	pass_gate_a: assert property ($rose(CARD_DATA_LINE_OE) |-> !READY_OE)
		else $error("data passed while not ready");
	timer_restart_a: assert property ($rose(READY_OE) |->
		low_q >= STUCK_CYCLES - 2 || !$past(ENABLE, 4))
		else $error("stuck break too early");
	// every pin only ever pulls low; its enable alone says whether it does
	low_drive_a: assert property (!BACKPLANE_DATA_LINE_O && !BACKPLANE_CLOCK_LINE_O &&
		!CARD_DATA_LINE_O && !CARD_CLOCK_LINE_O && !READY_O)
		else $error("open-drain value not low");
endmodule

//--- tb/bus_parties.sv
// parties on both sides of the buffer: pulls, a backplane clock, pull-ups
// assumes wire order bp data, bp clock, card data, card clock
`timescale 1ns/1ps
module bus_parties
(
	// bench pulls and design pulls
	input wire logic [3:0] pull,
	input wire logic run,
	input wire logic [3:0] dut_oe,
	// resolved wires
	output logic [3:0] wire_lvl
);
	logic tick = 1'b0;
	// backplane clock at 125 ns, still between frames
	always
	begin
		if (run)
			#62.5 tick = ~tick;
		else
		begin
			tick = 1'b0;
			@(run);
		end
	end
	// open drain: any pull wins, else the pull-up
	assign wire_lvl = ~(pull | dut_oe | {2'h0, tick, 1'b0});
endmodule

//--- tb/test_bus_buffer.sv
// self-checking bench of the buffer's connection control
// assumes small stuck and idle counts; the parties resolve the wires
`timescale 1ns/1ps
module test_bus_buffer
	import bus_buffer_pkg::*;
;
	localparam int STK = 200;
	localparam int IDL = 50;
	logic CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic ENABLE = 1'b0;
	logic [3:0] pull = 4'h0;
	logic run = 1'b0;
	wire logic [3:0] oe;
	logic [3:0] lvl;
	logic READY_O;
	logic READY_OE;
	int miscompares = 0;
	int n_checks = 0;
	int n;
	// one pull and the pull that should answer across the link
	logic [3:0] row_pull [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
	logic [3:0] row_oe [4] = '{4'h4, 4'h8, 4'h1, 4'h2};
	// clock
	initial
	begin
		forever #4 CLK = ~CLK;
	end
	bus_parties parties (.pull, .run, .dut_oe(oe), .wire_lvl(lvl));
	bus_buffer #(.STUCK_CYCLES(STK), .IDLE_CYCLES(IDL)) uut
	(
		.CLK, .ARST_N, .ENABLE,
		.BACKPLANE_DATA_LINE_I(lvl[0]), .BACKPLANE_DATA_LINE_O(),
		.BACKPLANE_DATA_LINE_OE(oe[0]), .BACKPLANE_CLOCK_LINE_I(lvl[1]),
		.BACKPLANE_CLOCK_LINE_O(), .BACKPLANE_CLOCK_LINE_OE(oe[1]),
		.CARD_DATA_LINE_I(lvl[2]), .CARD_DATA_LINE_O(), .CARD_DATA_LINE_OE(oe[2]),
		.CARD_CLOCK_LINE_I(lvl[3]), .CARD_CLOCK_LINE_O(), .CARD_CLOCK_LINE_OE(oe[3]),
		.READY_O, .READY_OE
	);
	// ----
	// tasks
	// ----
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	// sample a step after the edge so its updates have landed
	task automatic cyc(input int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask
	task automatic drive(input logic [3:0] p);
		@(posedge CLK);
		pull <= p;
	endtask
	task automatic wait_ready(input logic v, input int lim);
		n = 0;
		// let the updates of the launching edge land before the first look
		#1;
		while (READY_OE !== v && n < lim)
		begin
			cyc(1);
			n++;
		end
		check(READY_OE === v, "ready wait");
		if (READY_OE !== v)
			finish_test();
	endtask
	// ----
	// sequence
	// ----
	initial
	begin
		cyc(4);
		check(READY_OE === 1'b1 && READY_O === 1'b0 && oe === 4'h0, "reset state");
		@(posedge CLK);
		ARST_N <= 1'b1;
		ENABLE <= 1'b1;
		wait_ready(1'b0, IDL + 40);
		check(n >= IDL, "idle wait short");
		for (int i = 0; i < 4; i++)
		begin
			drive(row_pull[i]);
			cyc(12);
			check(oe === row_oe[i], "low not passed");
			drive(4'h0);
			cyc(20);
			check(oe === 4'h0, "low not released");
		end
		// a frame of backplane clock; the card clock follows about half the time
		@(posedge CLK);
		run <= 1'b1;
		n = 0;
		repeat (250)
		begin
			cyc(1);
			n += int'(oe[3] === 1'b1);
		end
		check(n > 80 && n < 170, "clock not passed");
		@(posedge CLK);
		run <= 1'b0;
		drive(4'h1);
		cyc(12);
		@(posedge CLK);
		ENABLE <= 1'b0;
		cyc(9);
		check(READY_OE === 1'b1 && oe === 4'h0, "enable off");
		@(posedge CLK);
		ENABLE <= 1'b1;
		cyc(IDL + 20);
		check(READY_OE === 1'b1, "link without stop");
		drive(4'h0);
		wait_ready(1'b0, IDL / 2);
		// both card lines stuck, so every one of the pulses is given
		drive(4'hC);
		wait_ready(1'b1, STK + 20);
		check(n >= STK, "stuck break early");
		n = 0;
		repeat (22000)
		begin
			cyc(1);
			n += int'(oe[3] === 1'b1);
		end
		check(n > 15 * 625 + 300 && n < 17 * 625 - 300, "pulse count");
		check(READY_OE === 1'b1, "link during stuck");
		drive(4'h0);
		wait_ready(1'b0, 800);
		repeat (2)
		begin
			drive(4'h4);
			cyc(STK - 30);
			drive(4'h0);
			cyc(10);
		end
		check(READY_OE === 1'b0, "timer kept count");
		// a third enable cycle on a quiet bus connects by idle time alone
		@(posedge CLK);
		ENABLE <= 1'b0;
		cyc(10);
		check(READY_OE === 1'b1 && oe === 4'h0, "enable off quiet");
		@(posedge CLK);
		ENABLE <= 1'b1;
		wait_ready(1'b0, IDL + 40);
		check(n >= IDL, "idle relink short");
		cyc(30);
		check(READY_OE === 1'b0, "idle link lost");
		finish_test();
	end
endmodule
bind bus_buffer bus_buffer_props
	#(.STUCK_CYCLES(STUCK_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)) props
(
	.CLK, .ARST_N, .ENABLE, .BACKPLANE_DATA_LINE_I, .BACKPLANE_CLOCK_LINE_I,
	.CARD_DATA_LINE_I, .CARD_CLOCK_LINE_I, .BACKPLANE_DATA_LINE_OE,
	.BACKPLANE_CLOCK_LINE_OE, .CARD_DATA_LINE_OE, .CARD_CLOCK_LINE_OE,
	.READY_O, .READY_OE, .BACKPLANE_DATA_LINE_O, .BACKPLANE_CLOCK_LINE_O,
	.CARD_DATA_LINE_O, .CARD_CLOCK_LINE_O
);
